/* File: shared/fsa_pkg.sv */
/*
  Constants and carrier types for the fault status aggregator.
  Assumes a byte-wide register command port fed by a serial bus engine.
*/
package fsa_pkg;
  // ==========================================
  // Register codes
  localparam logic [7:0] FSA_WP_CODE    = 8'h10; // Write protect control
  localparam logic [7:0] FSA_INDEX_CODE = 8'hc0; // fault_location_index
  localparam logic [7:0] FSA_BUSW_CODE  = 8'hd2; // bus_voltage_warning_status
  // ==========================================
  // Field positions and reset values
  localparam int         FSA_WP_BIT     = 7;     // 1 blocks writes
  localparam int         FSA_ALERT_BIT  = 7;     // Index summary bit
  localparam logic [7:0] FSA_BUSW_RST   = 8'h00;
  localparam logic [7:0] FSA_INDEX_RST  = 8'h00;
  localparam logic [7:0] FSA_WP_RST     = 8'h00;
  localparam logic [7:0] FSA_UNMAP_RD   = 8'h00; // Unmapped read value
  // Mode qualification: step-down bits 0,1,6; step-up bits 2..5,7
  localparam logic [7:0] FSA_BUCK_MASK  = 8'h43;
  localparam logic [7:0] FSA_BOOST_MASK = 8'hbc;
  // ==========================================
  // Timing counts
  localparam int         FSA_SYNC_DEPTH = 3;     // Pin synchroniser flops
  localparam int         FSA_RD_LAT     = 1;     // Cycles to read data

  // Command from the bus engine
  typedef struct packed {
    logic       valid; // One-cycle request
    logic       write; // 1 write, 0 read
    logic [7:0] code;  // Register code
    logic [7:0] wdata; // Write byte
  } fsa_cmd_s;

  // Read answer
  typedef struct packed {
    logic       valid; // One-cycle answer
    logic [7:0] data;  // Read byte
  } fsa_rsp_s;
endpackage : fsa_pkg

/* File: core/fsa_top.sv */
/*
  Fault status aggregator: bus warning status flags, fault index
  summary, write protection and the active-low alert pin.
  Assumes warning detectors are asynchronous levels, the mode input and
  the flags of status registers two to seven come from the same clock.
*/
`timescale 1ns/1ns
// Overview of operation
// - Index bit n shows status register n+1 nonzero
// - Index bit 7 and pin flag any fault
// - Step-down: low bus output overvoltage sets bit0
// - Step-down: low bus output undervoltage sets bit1
// - Step-up: low bus input overvoltage sets bit2
// - Step-up: low bus input undervoltage sets bit3
// - Step-up: high bus output overvoltage sets bit4
// - Step-up: high bus output undervoltage sets bit5
// - Step-down: high bus input overvoltage sets bit6
// - Step-up: high bus input undervoltage sets bit7
// - Status resets zero, read/write, write protected
// - Alert pin drops as soon as fault seen
// - Flags stick until clear-all or write-back
module fsa_top (
  input  wire logic            clock,             // 25 MHz
  input  wire logic            reset_n,           // Sync, active low
  input  wire fsa_pkg::fsa_cmd_s cmd,             // Register request
  input  wire logic            clear_all,         // Clear-all strobe
  input  wire logic            step_up_mode,      // 1 step-up, 0 down
  input  wire logic [7:0]      warn_detect,       // Async detectors
  input  wire logic [5:0]      other_reg_nonzero, // Registers 2..7
  output fsa_pkg::fsa_rsp_s    rsp,               // Read answer
  output logic                 fault_alert_pin_n  // Active-low alert
);
  import fsa_pkg::*;

  // ==========================================
  // Detector synchronisers
  logic [7:0] s1_reg, s2_reg, s3_reg;        // Three-flop chains
  logic [7:0] stable_reg, stable_next;       // Agreed levels

  // Second and third must agree before a change counts
  always_comb begin
    stable_next = stable_reg;
    for (int i = 0; i < 8; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        stable_next[i] = s3_reg[i];
      end
    end
  end

  // Synchroniser flops, one generate branch per detector
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_sync
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          s1_reg[g]     <= 1'b0;
          s2_reg[g]     <= 1'b0;
          s3_reg[g]     <= 1'b0;
          stable_reg[g] <= 1'b0;
        end else begin
          s1_reg[g]     <= warn_detect[g]; // First flop: read only by s2
          s2_reg[g]     <= s1_reg[g];
          s3_reg[g]     <= s2_reg[g];
          stable_reg[g] <= stable_next[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // Command decode
  logic wp_reg, wp_next;        // Write protect bit
  logic wr_any;                 // Any write request
  logic wr_ok;                  // Write allowed by protection
  logic wr_busw;                // Accepted write-back to status
  logic clr_ok;                 // Accepted clear-all

  // Writes pass only while protection is off, except to the WP register
  always_comb begin
    wr_any  = cmd.valid && cmd.write;
    wr_ok   = wr_any && !wp_reg;
    wr_busw = wr_ok && (cmd.code == FSA_BUSW_CODE);
    clr_ok  = clear_all && !wp_reg;
  end

  // Write-protect register always writable so software can unlock
  always_comb begin
    wp_next = wp_reg;
    if (wr_any && (cmd.code == FSA_WP_CODE)) begin
      wp_next = cmd.wdata[FSA_WP_BIT];
    end
  end

  // ==========================================
  // Bus warning status flags
  logic [7:0] status_reg, status_next; // bus_voltage_warning_status
  logic [7:0] set_vec;                 // Mode-qualified detections
  logic [7:0] clr_vec;                 // Bits being cleared

  // Each detector is gated by the conversion mode it belongs to
  always_comb begin
    if (step_up_mode) begin
      set_vec = stable_reg & FSA_BOOST_MASK;
    end else begin
      set_vec = stable_reg & FSA_BUCK_MASK;
    end
  end

  // Write-back of a set bit clears it; a fresh detection wins
  always_comb begin
    clr_vec = 8'h00;
    if (clr_ok) begin
      clr_vec = 8'hff;
    end else if (wr_busw) begin
      clr_vec = cmd.wdata & status_reg;
    end
    status_next = (status_reg & ~clr_vec) | set_vec;
  end

  // ==========================================
  // Fault index and alert
  logic [7:0] index_reg, index_next;   // fault_location_index
  logic       alert_n_next;            // Next pin level

  // Index is derived state; writes to it are ignored on purpose
  always_comb begin
    index_next[0]   = |status_next;
    index_next[6:1] = other_reg_nonzero;
    index_next[FSA_ALERT_BIT] = |index_next[6:0];
    alert_n_next    = !index_next[FSA_ALERT_BIT];
  end

  // ==========================================
  // Read answer
  fsa_rsp_s rsp_next; // Next read answer for the rsp register

  // Unmapped codes read as zero; writes give no answer
  always_comb begin
    rsp_next.valid = cmd.valid && !cmd.write;
    if (cmd.code == FSA_BUSW_CODE) begin
      rsp_next.data = status_reg;
    end else if (cmd.code == FSA_INDEX_CODE) begin
      rsp_next.data = index_reg;
    end else if (cmd.code == FSA_WP_CODE) begin
      rsp_next.data = {wp_reg, 7'h00};
    end else begin
      rsp_next.data = FSA_UNMAP_RD;
    end
    if (!rsp_next.valid) begin
      rsp_next.data = 8'h00;
    end
  end

  // ==========================================
  // State registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wp_reg            <= FSA_WP_RST[FSA_WP_BIT];
      status_reg        <= FSA_BUSW_RST;
      index_reg         <= FSA_INDEX_RST;
      fault_alert_pin_n <= 1'b1;
      rsp               <= '0;
    end else begin
      wp_reg            <= wp_next;
      status_reg        <= status_next;
      index_reg         <= index_next;
      fault_alert_pin_n <= alert_n_next;
      rsp               <= rsp_next;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // Detector held long enough to pass the synchroniser
  sequence s_buck_ov_held;
    (warn_detect[0] && !step_up_mode)[*4];
  endsequence

  sequence s_boost_iuv_held;
    (warn_detect[7] && step_up_mode)[*4];
  endsequence

  sequence s_buck_ouv_held;
    (warn_detect[1] && !step_up_mode)[*4];
  endsequence

  sequence s_boost_lov_held;
    (warn_detect[2] && step_up_mode)[*4];
  endsequence

  sequence s_boost_hov_held;
    (warn_detect[4] && step_up_mode)[*4];
  endsequence

  sequence s_buck_hov_held;
    (warn_detect[6] && !step_up_mode)[*4];
  endsequence

  // Index bit 0 and its status register move on the same edge

  a_idx_low_or: assert property (index_reg[0] == |status_reg)
    else $error("index bit 0 does not match status");

  // First edge after reset still shows the reset value, so skip it
  a_idx_others: assert property ($past(reset_n) |-> index_reg[6:1] == $past(other_reg_nonzero))
    else $error("index bits 6..1 wrong");

  a_idx_summary: assert property (index_reg[7] == |index_reg[6:0])
    else $error("index bit 7 not the OR of bits 6..0");

  a_alert_pin: assert property (fault_alert_pin_n == !index_reg[7])
    else $error("alert pin disagrees with index bit 7");

  a_buck_ov_set: assert property (s_buck_ov_held |=> ##1 status_reg[0])
    else $error("step-down overvoltage flag not set");

  a_boost_iuv_set: assert property (s_boost_iuv_held |=> ##1 status_reg[7])
    else $error("step-up input undervoltage flag not set");

  // Detector to flag takes the three flops, one agreement cycle and the status flop
  a_buck_uv_set: assert property (s_buck_ouv_held |=> ##1 status_reg[1])
    else $error("step-down output undervoltage flag not set");

  // Low bus input overvoltage only counts in step-up
  a_boost_lov_set: assert property (s_boost_lov_held |=> ##1 status_reg[2])
    else $error("step-up low bus overvoltage flag not set");

  // High bus output overvoltage only counts in step-up
  a_boost_hov_set: assert property (s_boost_hov_held |=> ##1 status_reg[4])
    else $error("step-up high bus overvoltage flag not set");

  // High bus input overvoltage only counts in step-down
  a_buck_hov_set: assert property (s_buck_hov_held |=> ##1 status_reg[6])
    else $error("step-down high bus overvoltage flag not set");

  // Step-up masks bits 1..0 from set_vec, so a clean pair stays clean in step-up
  a_mode_gate: assert property (step_up_mode && (status_reg[1:0] == 2'b00) |=>
                                (status_reg[1:0] == 2'b00))
    else $error("step-down flag set in step-up mode");

  a_flag_sticky: assert property (!clr_ok && !wr_busw |=>
                                  (($past(status_reg) & ~status_reg) == 8'h00))
    else $error("flag lost without a clear");

  a_wp_blocks: assert property (wp_reg && clear_all |=>
                                (($past(status_reg) & ~status_reg) == 8'h00))
    else $error("clear accepted while write protected");

  a_clear_all: assert property (clr_ok && (set_vec == 8'h00) |=>
                                status_reg == 8'h00)
    else $error("clear-all left flags set");

  a_alert_fast: assert property ($rose(|status_next) |=> !fault_alert_pin_n)
    else $error("alert pin late");

  a_read_status: assert property (cmd.valid && !cmd.write &&
                                  cmd.code == FSA_BUSW_CODE |=>
                                  rsp.valid && rsp.data == $past(status_reg))
    else $error("status read wrong");

  // Protection bit itself stays writable so software can unlock
  a_wp_write: assert property (wr_any && (cmd.code == FSA_WP_CODE) |=>
                               wp_reg == $past(cmd.wdata[FSA_WP_BIT]))
    else $error("write protect bit not updated");

  // Accepted write-back leaves none of the written bits set
  a_busw_clear: assert property (wr_busw && (set_vec == 8'h00) |=>
                                 ((status_reg & $past(cmd.wdata)) == 8'h00))
    else $error("write-back did not clear flags");

  // A detection in the clear cycle must survive it
  a_set_wins: assert property ((set_vec != 8'h00) |=>
                               ((status_reg & $past(set_vec)) == $past(set_vec)))
    else $error("fresh detection lost");

  // Step-down: no step-up flag may newly appear
  a_buck_gate: assert property (!step_up_mode |=>
                                ((status_reg & ~$past(status_reg) & FSA_BOOST_MASK) == 8'h00))
    else $error("step-up flag set in step-down mode");

  // Step-up: no step-down flag may newly appear
  a_boost_gate: assert property (step_up_mode |=>
                                 ((status_reg & ~$past(status_reg) & FSA_BUCK_MASK) == 8'h00))
    else $error("step-down flag set in step-up mode");

  // Pin released whenever no status register holds a flag
  a_alert_release: assert property ((index_reg[6:0] == 7'h00) |-> fault_alert_pin_n)
    else $error("alert pin held with no fault");

  // Index read returns the summary of the cycle of the request
  a_read_index: assert property (cmd.valid && !cmd.write &&
                                 cmd.code == FSA_INDEX_CODE |=>
                                 rsp.valid && rsp.data == $past(index_reg))
    else $error("index read wrong");

  // Writes never produce an answer
  a_write_silent: assert property (cmd.valid && cmd.write |=> !rsp.valid)
    else $error("answer given to a write");

  // Idle answer carries zero data
  a_rsp_idle: assert property (!rsp.valid |-> (rsp.data == 8'h00))
    else $error("read data without valid");

endmodule : fsa_top

/* File: sim/fsa_host_model.sv */
/*
  Host model: the microcontroller side of the register port.
  Assumes the device samples on the rising edge; requests move at falling.
*/
`timescale 1ns/1ns
module fsa_host_model (
  input  wire logic              clock,    // Device clock
  input  wire fsa_pkg::fsa_rsp_s rsp,      // Read answer
  output fsa_pkg::fsa_cmd_s      cmd,      // Register request
  output logic                   clear_all // Clear-all strobe
);
  import fsa_pkg::*;
  // ==========================================
  // Idle at time zero
  initial begin
    cmd = '0;
    clear_all = 1'b0;
  end
  // ==========================================
  // One request for one cycle; the answer stands the cycle after
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [7:0] wd, output fsa_rsp_s r);
    @(negedge clock);
    cmd = '{1'b1, wr, code, wd};
    @(negedge clock);
    r = rsp;
    cmd = '0;
  endtask : xfer
  // Clear-all; while protected and without unlocking first the device ignores it
  task automatic clear_flags(input logic unlock);
    fsa_rsp_s r;
    if (unlock) xfer(1'b1, FSA_WP_CODE, 8'h00, r);
    @(negedge clock);
    clear_all = 1'b1;
    @(negedge clock);
    clear_all = 1'b0;
  endtask : clear_flags
endmodule : fsa_host_model

/* File: sim/tb.sv */
/*
  Self-checking bench for the fault status aggregator.
  Assumes a host model on the register port; detectors driven here.
*/
`timescale 1ns/1ns
module tb;
  import fsa_pkg::*;
  logic       clock, reset_n, step_up_mode, clear_all, pin_n, mode;
  logic [7:0] warn_detect, st, pat, idx;
  logic [5:0] other_reg_nonzero, oth;
  fsa_cmd_s   cmd;
  fsa_rsp_s   rsp, r;
  int         err_count, check_count, seed;
  // ==========================================
  // Design and host
  fsa_top fsa_top_inst (.clock(clock), .reset_n(reset_n), .cmd(cmd),
    .clear_all(clear_all), .step_up_mode(step_up_mode),
    .warn_detect(warn_detect), .other_reg_nonzero(other_reg_nonzero),
    .rsp(rsp), .fault_alert_pin_n(pin_n));
  fsa_host_model fsa_host_model_inst (.clock(clock), .rsp(rsp), .cmd(cmd),
    .clear_all(clear_all));
  // ==========================================
  // Clock, 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Expected flags: only detectors of the current mode count
  function automatic logic [7:0] exp_status(input logic [7:0] p, input logic m);
    return p & (m ? FSA_BOOST_MASK : FSA_BUCK_MASK);
  endfunction : exp_status
  // Expected index: bit 0 for status, 1..6 others, 7 any
  function automatic logic [7:0] exp_index(input logic [7:0] s, input logic [5:0] o);
    return {(|s) | (|o), o, |s};
  endfunction : exp_index
  // ==========================================
  // Compare tasks and verdict
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic read_chk(input logic [7:0] code, input logic [7:0] exp);
    fsa_model_read(code);
    chk_bit(r.valid, 1'b1);
    chk_byte(r.data, exp);
  endtask : read_chk
  task automatic fsa_model_read(input logic [7:0] code);
    fsa_host_model_inst.xfer(1'b0, code, 8'h00, r);
  endtask : fsa_model_read
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Hold a detector pattern long enough to pass the synchroniser
  task automatic pulse_warn(input logic [7:0] p);
    warn_detect = p;
    repeat (5) @(negedge clock);
    warn_detect = 8'h00;
    repeat (4) @(negedge clock);
  endtask : pulse_warn
  // ==========================================
  // Watchdog against a hang
  initial begin
    repeat (100000) @(posedge clock);
    err_count++;
    end_sim();
  end
  // ==========================================
  // Main sequence
  initial begin
    seed = 20;
    reset_n = 1'b0;
    step_up_mode = 1'b0;
    warn_detect = 8'h00;
    other_reg_nonzero = 6'h00;
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    chk_bit(pin_n, 1'b1);
    read_chk(FSA_BUSW_CODE, 8'h00);
    read_chk(FSA_INDEX_CODE, 8'h00);
    read_chk(8'h55, 8'h00);
    // Each bit in both modes, then random patterns and other registers
    for (int k = 0; k < 24; k++) begin
      pat = (k < 16) ? 8'h01 << k[3:1] : 8'($random(seed));
      mode = (k < 16) ? k[0] : 1'($random(seed));
      oth = (k < 16) ? 6'h00 : 6'($random(seed));
      step_up_mode = mode;
      other_reg_nonzero = oth;
      pulse_warn(pat);
      st = exp_status(pat, mode);
      idx = exp_index(st, oth);
      read_chk(FSA_BUSW_CODE, st);
      read_chk(FSA_INDEX_CODE, idx);
      chk_bit(pin_n, ~idx[7]);
      // Clear by writing the same value back
      fsa_host_model_inst.xfer(1'b1, FSA_BUSW_CODE, st, r);
      other_reg_nonzero = 6'h00;
      read_chk(FSA_BUSW_CODE, 8'h00);
      chk_bit(pin_n, 1'b1);
    end
    // Index is not writable
    fsa_host_model_inst.xfer(1'b1, FSA_INDEX_CODE, 8'hff, r);
    read_chk(FSA_INDEX_CODE, 8'h00);
    // Protected: write-back and clear-all both refused
    fsa_host_model_inst.xfer(1'b1, FSA_WP_CODE, 8'h80, r);
    step_up_mode = 1'b0;
    pulse_warn(8'h41);
    fsa_host_model_inst.xfer(1'b1, FSA_BUSW_CODE, 8'h41, r);
    fsa_host_model_inst.clear_flags(1'b0);
    read_chk(FSA_BUSW_CODE, 8'h41);
    chk_bit(pin_n, 1'b0);
    fsa_host_model_inst.clear_flags(1'b1);
    read_chk(FSA_BUSW_CODE, 8'h00);
    chk_bit(pin_n, 1'b1);
    // Protection bit reads back; a mid-run reset then clears everything
    fsa_host_model_inst.xfer(1'b1, FSA_WP_CODE, 8'h80, r);
    read_chk(FSA_WP_CODE, 8'h80);
    pulse_warn(8'h41);
    chk_bit(pin_n, 1'b0);
    @(negedge clock);
    reset_n = 1'b0;
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    chk_bit(pin_n, 1'b1);
    read_chk(FSA_BUSW_CODE, 8'h00);
    read_chk(FSA_WP_CODE, 8'h00);
    read_chk(FSA_INDEX_CODE, 8'h00);
    end_sim();
  end
endmodule : tb
